// ### hdl/flash_host_pkg.sv
package flash_host_pkg;

   // ==========================================================
   // timing
   localparam int CLK_NS = 8;
   localparam int PHASE_NS = 50; // least setup, strobe and hold time
   localparam int CYC_PHASE = (PHASE_NS + CLK_NS - 1) / CLK_NS;

   // ==========================================================
   // flash command codes
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

   // ==========================================================
   // sequencer_status bit positions
   localparam int SR_READY = 7;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam logic [7:0] SR_POLL_MASK = 8'hfe; // bit 0 is reserved
   localparam logic [7:0] SR_ERR_MASK = 8'h3a;  // bits 5,4,3,1
   localparam logic [7:0] SR_RESET = 8'h00;

   // ==========================================================
   // own register map, byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_ADDR = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam int CTRL_ERASE = 0;
   localparam int CTRL_CLEAR = 1;
   localparam int CTRL_ARRAY = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int FA_W = 21;

   // ==========================================================
   // pin bundle driven toward the flash
   typedef struct packed {
      logic [FA_W-1:0] addr;
      logic [7:0] dq_o;
      logic dq_oe;
      logic ce_n;
      logic we_n;
      logic oe_n;
   } flash_pins_t;

   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD}
      phase_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_CONFIRM, ST_WAIT, ST_POLL, ST_ARRAY, ST_CLEAR
   } host_state_t;

endpackage

// ### hdl/flash_bus_cycle.sv
`timescale 1ns/1ns
module flash_bus_cycle (
   input wire logic aclk,                          // system clock
   input wire logic aresetn,                       // sync reset
   input wire logic start,                         // begin one cycle
   input wire logic is_write,                      // 1 write, 0 read
   input wire logic [flash_host_pkg::FA_W-1:0] addr, // flash address
   input wire logic [7:0] wdata,                   // write data
   input wire logic [7:0] dq_i,                    // data pins in
   output logic idle,                              // ready to start
   output logic done,                              // cycle finished
   output logic [7:0] rdata,                       // sampled read data
   output flash_host_pkg::flash_pins_t pins        // flash pin drive
);

   typedef struct packed {
      flash_host_pkg::phase_t ph;
      logic [3:0] cnt;
      logic wr;
      flash_host_pkg::flash_pins_t pins;
      logic [7:0] rdata;
      logic done;
      logic [7:0] dq_s1;
      logic [7:0] dq_s2;
   } cycle_regs_t;

   localparam logic [3:0] PH_LAST = 4'(flash_host_pkg::CYC_PHASE - 1);

   cycle_regs_t q, d;

   // ==========================================================
   // setup, strobe, hold sequence on the pins
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.dq_s1 = dq_i;
      d.dq_s2 = q.dq_s1;
      if (q.ph != flash_host_pkg::PH_IDLE) begin
         d.cnt = q.cnt - 4'h1;
      end
      case (q.ph)
         flash_host_pkg::PH_IDLE: begin
            if (start) begin
               d.ph = flash_host_pkg::PH_SETUP;
               d.cnt = PH_LAST;
               d.wr = is_write;
               d.pins.addr = addr;
               d.pins.dq_o = wdata;
               d.pins.dq_oe = is_write;
               d.pins.ce_n = 1'b0;
            end
         end
         flash_host_pkg::PH_SETUP: begin
            if (q.cnt == 4'h0) begin
               d.ph = flash_host_pkg::PH_STROBE;
               d.cnt = PH_LAST;
               d.pins.we_n = ~q.wr;
               d.pins.oe_n = q.wr;
            end
         end
         flash_host_pkg::PH_STROBE: begin
            if (q.cnt == 4'h0) begin
               d.ph = flash_host_pkg::PH_HOLD;
               d.cnt = PH_LAST;
               d.pins.we_n = 1'b1;
               d.pins.oe_n = 1'b1;
               if (!q.wr) begin
                  d.rdata = q.dq_s2; // sampled at end of strobe
               end
            end
         end
         flash_host_pkg::PH_HOLD: begin
            if (q.cnt == 4'h0) begin
               d.ph = flash_host_pkg::PH_IDLE;
               d.pins.ce_n = 1'b1;
               d.pins.dq_oe = 1'b0;
               d.done = 1'b1;
            end
         end
         default: d.ph = flash_host_pkg::PH_IDLE;
      endcase
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ph <= flash_host_pkg::PH_IDLE;
         q.pins.ce_n <= 1'b1;
         q.pins.we_n <= 1'b1;
         q.pins.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign idle = (q.ph == flash_host_pkg::PH_IDLE);
   assign done = q.done;
   assign rdata = q.rdata;
   assign pins = q.pins;

endmodule

// ### hdl/flash_erase_host.sv
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// How it works
// [R1] device shows ready bit when sequencer idle
// [R2] device flags suspended erase in status
// [R3] device flags failed erase or unlock
// [R4] device flags failed program or lock set
// [R5] device aborts and flags low supply
// [R6] device flags suspended byte write
// [R7] device aborts and flags protection lock
// [R8] host masks reserved status bit zero
// [R9] both error bits mean bad sequence
// [R10] device samples supply only after sequences
// [R11] device checks locks only after sequences
// [R12] device reports lock states as codes
// [R13] host trusts status only when ready
// [R14] erase is setup 20h then confirm D0h
// [R15] host writes FFh to restore array reads
// [R16] device keeps error bits until cleared
// [R17] host clears status before any retry
// [R18] device flags locked block during erase
// [R19] device returns status until next command
// [R20] locked block refuses erase unless overridden
// [R21] status shows ready, no errors after reset
module flash_erase_host #(
   parameter logic [7:0] CLEAR_CMD = 8'h50 // clear status command code
) (
   input wire logic aclk,                   // system clock
   input wire logic aresetn,                // sync reset, active low
   input wire logic [3:0] s_awaddr,         // write address
   input wire logic s_awvalid,              // write address valid
   output logic s_awready,                  // write address ready
   input wire logic [31:0] s_wdata,         // write data
   input wire logic [3:0] s_wstrb,          // write strobes
   input wire logic s_wvalid,               // write data valid
   output logic s_wready,                   // write data ready
   output logic [1:0] s_bresp,              // write response
   output logic s_bvalid,                   // write response valid
   input wire logic s_bready,               // write response ready
   input wire logic [3:0] s_araddr,         // read address
   input wire logic s_arvalid,              // read address valid
   output logic s_arready,                  // read address ready
   output logic [31:0] s_rdata,             // read data
   output logic [1:0] s_rresp,              // read response
   output logic s_rvalid,                   // read data valid
   input wire logic s_rready,               // read data ready
   input wire logic [7:0] flash_dq_i,       // flash data pins in
   output logic [7:0] flash_dq_o,           // flash data pins out
   output logic flash_dq_oe,                // flash data drive enable
   output logic [20:0] flash_addr,          // flash address pins
   output logic flash_ce_n,                 // chip enable, low active
   output logic flash_we_n,                 // write enable, low active
   output logic flash_oe_n,                 // output enable, low active
   input wire logic ready_busy_pin          // high when flash ready
);

   typedef struct packed {
      flash_host_pkg::host_state_t st;
      logic pend;
      logic [20:0] addr;
      logic [7:0] sr;
      logic done;
      logic err;
      logic req_erase;
      logic req_clear;
      logic req_array;
      logic aw_got;
      logic [3:0] awa;
      logic w_got;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rb_s1;
      logic rb_s2;
   } host_regs_t;

   host_regs_t q, d;
   logic cyc_start, cyc_write, cyc_idle, cyc_done;
   logic [7:0] cyc_wdata, cyc_rdata;
   flash_host_pkg::flash_pins_t pins;

   // ==========================================================
   // helpers
   function automatic logic [1:0] reg_index(input logic [3:0] a);
      case (a)
         flash_host_pkg::OFS_CTRL: reg_index = 2'h1;
         flash_host_pkg::OFS_ADDR: reg_index = 2'h2;
         flash_host_pkg::OFS_STATUS: reg_index = 2'h3;
         default: reg_index = 2'h0;
      endcase
   endfunction

   function automatic logic [7:0] cmd_of(
      input flash_host_pkg::host_state_t s);
      case (s)
         flash_host_pkg::ST_SETUP: cmd_of = flash_host_pkg::CMD_ERASE_SETUP;
         flash_host_pkg::ST_CONFIRM:
            cmd_of = flash_host_pkg::CMD_ERASE_CONFIRM;
         flash_host_pkg::ST_CLEAR: cmd_of = CLEAR_CMD;
         default: cmd_of = flash_host_pkg::CMD_READ_ARRAY;
      endcase
   endfunction

   // ==========================================================
   // flash bus cycles
   assign cyc_write = (q.st != flash_host_pkg::ST_POLL);
   assign cyc_wdata = cmd_of(q.st);
   assign cyc_start = !q.pend && (q.st != flash_host_pkg::ST_IDLE) &&
                      (q.st != flash_host_pkg::ST_WAIT);

   flash_bus_cycle u_cycle (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(cyc_start),
      .is_write(cyc_write),
      .addr(q.addr),
      .wdata(cyc_wdata),
      .dq_i(flash_dq_i),
      .idle(cyc_idle),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .pins(pins)
   );

   // ==========================================================
   // sequencer and register file
   always_comb begin
      d = q;
      d.rb_s1 = ready_busy_pin;
      d.rb_s2 = q.rb_s1;
      if (cyc_start && cyc_idle) d.pend = 1'b1;
      if (cyc_done) d.pend = 1'b0;
      case (q.st)
         flash_host_pkg::ST_IDLE: begin
            if (q.req_clear) begin
               d.req_clear = 1'b0;
               d.st = flash_host_pkg::ST_CLEAR;
            end else if (q.req_erase) begin
               d.req_erase = 1'b0;
               if (!q.err) begin // see [R17]
                  d.done = 1'b0;
                  d.st = flash_host_pkg::ST_SETUP; // see [R14]
               end
            end else if (q.req_array) begin
               d.req_array = 1'b0;
               d.st = flash_host_pkg::ST_ARRAY;
            end
         end
         flash_host_pkg::ST_SETUP: begin
            if (cyc_done) d.st = flash_host_pkg::ST_CONFIRM; // see [R14]
         end
         flash_host_pkg::ST_CONFIRM: begin
            if (cyc_done) d.st = flash_host_pkg::ST_WAIT;
         end
         flash_host_pkg::ST_WAIT: begin
            if (q.rb_s2) d.st = flash_host_pkg::ST_POLL; // see [R13]
         end
         flash_host_pkg::ST_POLL: begin
            if (cyc_done) begin
               if (cyc_rdata[flash_host_pkg::SR_READY]) begin // see [R13]
                  d.sr = cyc_rdata & flash_host_pkg::SR_POLL_MASK; // see [R8]
                  d.err = |(cyc_rdata & flash_host_pkg::SR_ERR_MASK);
                  d.done = 1'b1;
                  d.st = flash_host_pkg::ST_ARRAY; // see [R15]
               end else begin
                  d.st = flash_host_pkg::ST_WAIT;
               end
            end
         end
         flash_host_pkg::ST_ARRAY: begin
            if (cyc_done) d.st = flash_host_pkg::ST_IDLE;
         end
         flash_host_pkg::ST_CLEAR: begin
            if (cyc_done) begin
               d.err = 1'b0;
               d.sr = flash_host_pkg::SR_RESET;
               d.st = flash_host_pkg::ST_IDLE;
            end
         end
         default: d.st = flash_host_pkg::ST_IDLE;
      endcase

      // axi write side, address and data taken in either order
      if (s_awvalid && s_awready) begin
         d.aw_got = 1'b1;
         d.awa = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         d.w_got = 1'b1;
         d.wd = s_wdata;
         d.ws = s_wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = flash_host_pkg::RESP_OKAY;
         case (reg_index(q.awa))
            2'h1: begin
               if (q.ws[0]) begin // a new request wins over consumption
                  if (q.wd[flash_host_pkg::CTRL_ERASE]) d.req_erase = 1'b1;
                  if (q.wd[flash_host_pkg::CTRL_CLEAR]) d.req_clear = 1'b1;
                  if (q.wd[flash_host_pkg::CTRL_ARRAY]) d.req_array = 1'b1;
               end
            end
            2'h2: begin
               if (q.ws[0]) d.addr[7:0] = q.wd[7:0];
               if (q.ws[1]) d.addr[15:8] = q.wd[15:8];
               if (q.ws[2]) d.addr[20:16] = q.wd[20:16];
            end
            2'h3: ; // status is read only
            default: d.bresp = flash_host_pkg::RESP_SLVERR;
         endcase
      end else if (q.bvalid && s_bready) begin
         d.bvalid = 1'b0;
      end

      // axi read side
      if (s_arvalid && s_arready) begin
         d.rvalid = 1'b1;
         d.rresp = flash_host_pkg::RESP_OKAY;
         case (reg_index(s_araddr))
            2'h1: d.rdata = {29'h0, q.req_array, q.req_clear, q.req_erase};
            2'h2: d.rdata = {11'h0, q.addr};
            2'h3: d.rdata = {16'h0, q.sr, 4'h0,
                             q.sr[flash_host_pkg::SR_ERASE_ERR] &
                             q.sr[flash_host_pkg::SR_PROG_ERR],
                             q.err, q.done,
                             q.st != flash_host_pkg::ST_IDLE};
            default: begin
               d.rdata = 32'h0;
               d.rresp = flash_host_pkg::RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && s_rready) begin
         d.rvalid = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.st <= flash_host_pkg::ST_IDLE;
         q.sr <= flash_host_pkg::SR_RESET;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign s_awready = !q.aw_got && !q.bvalid;
   assign s_wready = !q.w_got && !q.bvalid;
   assign s_bvalid = q.bvalid;
   assign s_bresp = q.bresp;
   assign s_arready = !q.rvalid;
   assign s_rvalid = q.rvalid;
   assign s_rdata = q.rdata;
   assign s_rresp = q.rresp;
   assign flash_dq_o = pins.dq_o;
   assign flash_dq_oe = pins.dq_oe;
   assign flash_addr = pins.addr;
   assign flash_ce_n = pins.ce_n;
   assign flash_we_n = pins.we_n;
   assign flash_oe_n = pins.oe_n;

   // ==========================================================
   // checks
   a_reserved_masked: assert property (@(posedge aclk) // see [R8]
      disable iff (!aresetn) q.sr[0] == 1'b0)
      else $error("reserved status bit kept");
   a_ready_capture: assert property (@(posedge aclk) // see [R13]
      disable iff (!aresetn) $rose(q.done) |->
         q.sr[flash_host_pkg::SR_READY] && $past(q.rb_s2))
      else $error("status captured while busy");
   a_erase_pair: assert property (@(posedge aclk) // see [R14]
      disable iff (!aresetn)
      (q.st == flash_host_pkg::ST_SETUP && cyc_done)
      |=> q.st == flash_host_pkg::ST_CONFIRM && cyc_start &&
          cyc_wdata == flash_host_pkg::CMD_ERASE_CONFIRM
          ##1 pins.addr == $past(pins.addr, 2))
      else $error("erase confirm not after setup");
   a_array_after: assert property (@(posedge aclk) // see [R15]
      disable iff (!aresetn)
      (q.st == flash_host_pkg::ST_POLL && cyc_done && cyc_rdata[7])
      |=> ##[1:40] (pins.we_n == 1'b0 && pins.dq_o == 8'hff))
      else $error("read array not written after erase");
   a_retry_block: assert property (@(posedge aclk) // see [R17]
      disable iff (!aresetn)
      (q.st == flash_host_pkg::ST_IDLE && q.err && !q.req_clear)
      |=> q.st != flash_host_pkg::ST_SETUP)
      else $error("erase retried with errors pending");

endmodule

// ### test/flash_device_model.sv
`timescale 1ns/1ns
// ==========================================================
// behavioural flash device: status register and erase engine
module flash_device_model #(
   parameter int BUSY_CLKS = 200 // erase duration in clocks
) (
   input wire logic aclk,          // timing reference
   input wire logic [20:0] addr,   // address pins
   input wire logic [7:0] dq_o,    // data from host
   input wire logic dq_oe,         // host drives data
   input wire logic ce_n,          // chip enable
   input wire logic we_n,          // write strobe
   input wire logic oe_n,          // read strobe
   output logic [7:0] dq_i,        // data to host
   output logic ready_busy_pin,    // high when ready
   input wire logic lock_blk,      // target block locked
   input wire logic override,      // reset pin at high level
   input wire logic vpp_low,       // supply too low
   input wire logic drop_setup,    // lose the next setup write
   output logic [7:0] sr,          // status register
   output logic array_mode,        // reads return array
   output logic [7:0] last_cmd,    // last command seen
   output int erases,              // erases started
   output logic [20:0] erase_addr  // address of last erase
);
   logic we_q;
   logic setup;
   logic [7:0] rd;
   logic [7:0] last;
   int cnt;

   // ==========================================================
   // power-up: ready, no suspend or error, reserved bit reads 1
   initial begin
      sr = 8'h81;
      we_q = 1'b1;
      setup = 1'b0;
      last = 8'h00;
      cnt = 0;
      erases = 0;
      array_mode = 1'b1;
      last_cmd = 8'h00;
      erase_addr = '0;
   end

   // status low bits are junk while busy; released bus flips
   assign rd = array_mode ? (addr[7:0] ^ 8'h3c) :
      (sr[7] ? sr : 8'h55);
   assign dq_i = (!ce_n && !oe_n) ? rd : ~last;
   assign ready_busy_pin = sr[7];

   // command decode on the rising write strobe, erase timer
   always @(posedge aclk) begin
      we_q <= we_n;
      if (!ce_n && !oe_n) last <= rd;
      if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) sr[7] <= 1'b1;
      if (!we_q && we_n && !ce_n && dq_oe) begin
         last_cmd <= dq_o;
         array_mode <= (dq_o == 8'hff);
         setup <= (dq_o == 8'h20) && !drop_setup;
         if (dq_o == 8'h50) sr[5:1] <= 5'h00;
         if (dq_o == 8'hd0) begin
            if (!setup) begin
               sr[5:4] <= 2'b11;
            end else if (vpp_low) begin
               {sr[5], sr[3]} <= 2'b11;
            end else if (lock_blk && !override) begin
               {sr[5], sr[1]} <= 2'b11;
            end else begin
               sr[7] <= 1'b0;
               cnt <= BUSY_CLKS;
               erases <= erases + 1;
               erase_addr <= addr;
            end
         end
      end
   end
endmodule

// ### test/test_flash_erase_host.sv
`timescale 1ns/1ns
// ==========================================================
// bench: register-level tests of the erase host
module test_flash_erase_host;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic [7:0] dq_i, dq_o, sr, last_cmd;
   logic [20:0] faddr, erase_addr;
   logic dq_oe, ce_n, we_n, oe_n, rb, array_mode;
   logic lock_blk, override, vpp_low, drop_setup;
   int erases, bad_count, checked;

   flash_erase_host dut (.aclk(aclk), .aresetn(aresetn),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
      .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
      .s_rvalid(rvalid), .s_rready(rready), .flash_dq_i(dq_i),
      .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_addr(faddr),
      .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
      .ready_busy_pin(rb));

   flash_device_model flash (.aclk(aclk), .addr(faddr), .dq_o(dq_o),
      .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .dq_i(dq_i), .ready_busy_pin(rb), .lock_blk(lock_blk),
      .override(override), .vpp_low(vpp_low), .drop_setup(drop_setup),
      .sr(sr), .array_mode(array_mode), .last_cmd(last_cmd),
      .erases(erases), .erase_addr(erase_addr));

   // ==========================================================
   // clock, 8 ns period
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // compare and count
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write: address and data together, wait for the response
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   // one read, data and response taken at the handshake edge
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // host status from device flags f; busy and done bits left out
   task automatic st_chk(input logic [7:0] f);
      rd(flash_host_pkg::OFS_STATUS);
      check("status", {16'h0000, f & flash_host_pkg::SR_POLL_MASK,
         4'h0, f[5] & f[4], |(f & flash_host_pkg::SR_ERR_MASK), 2'b00},
         {d[31:8], 4'h0, d[3:2], 2'b00});
   endtask

   // erase request, poll until idle, compare captured status
   task automatic erase(input logic [7:0] f);
      wr(flash_host_pkg::OFS_CTRL, 32'h0000_0001);
      do rd(flash_host_pkg::OFS_STATUS); while (d[0] !== 1'b0);
      check("done", 32'h1, {31'h0, d[1]});
      st_chk(f);
   endtask

   // clear status, wait for the host to settle, error flag drops
   task automatic clr;
      wr(flash_host_pkg::OFS_CTRL, 32'h0000_0002);
      do rd(flash_host_pkg::OFS_STATUS); while (d[0] !== 1'b0);
      check("cleared", 32'h0, {23'h0, d[15:8], d[2]});
      check("device cleared", 32'h81, {24'h0, sr});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      tally_and_finish;
   end

   // ==========================================================
   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {lock_blk, override, vpp_low, drop_setup} = '0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      bad_count = 0;
      checked = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check("device status", 32'h81, {24'h0, sr});
      st_chk(8'h00);
      check("busy done", 32'h0, {30'h0, d[1:0]});
      rd(flash_host_pkg::OFS_ADDR);
      check("addr reset", 32'h0, d);
      // unmapped offset
      rd(4'hc);
      check("rresp", {30'h0, flash_host_pkg::RESP_SLVERR}, {30'h0, r});
      check("rdata", 32'h0, d);
      wr(4'hc, 32'h1);
      check("bresp", {30'h0, flash_host_pkg::RESP_SLVERR}, {30'h0, r});
      // address register holds 21 bits
      wr(flash_host_pkg::OFS_ADDR, 32'hffff_ffff);
      check("bresp ok", {30'h0, flash_host_pkg::RESP_OKAY}, {30'h0, r});
      rd(flash_host_pkg::OFS_ADDR);
      check("rresp ok", {30'h0, flash_host_pkg::RESP_OKAY}, {30'h0, r});
      check("addr", 32'h001f_ffff, d);
      wr(flash_host_pkg::OFS_ADDR, 32'h0013_0456);
      // good erase, device back in array reads afterwards
      erase(8'h81);
      check("erases", 32'h1, 32'(erases));
      check("erase addr", 32'h0013_0456, {11'h0, erase_addr});
      check("last cmd", 32'hff, {24'h0, last_cmd});
      // locked block aborts with protection flag
      lock_blk <= 1'b1;
      erase(8'ha3);
      lock_blk <= 1'b0;
      // flags stay and a new erase is dropped until cleared
      wr(flash_host_pkg::OFS_CTRL, 32'h0000_0001);
      st_chk(8'ha3);
      check("busy", 32'h0, {31'h0, d[0]});
      check("erases", 32'h1, 32'(erases));
      clr;
      // low programming supply
      vpp_low <= 1'b1;
      erase(8'ha9);
      vpp_low <= 1'b0;
      clr;
      // high level on the reset pin beats the lock
      lock_blk <= 1'b1;
      override <= 1'b1;
      erase(8'h81);
      check("erases", 32'h2, 32'(erases));
      {lock_blk, override} <= 2'b00;
      // lost setup write gives a sequence error
      drop_setup <= 1'b1;
      erase(8'hb1);
      drop_setup <= 1'b0;
      clr;
      // explicit read array command
      wr(flash_host_pkg::OFS_CTRL, 32'h0000_0004);
      wait (array_mode === 1'b1);
      check("last cmd", 32'hff, {24'h0, last_cmd});
      tally_and_finish;
   end
endmodule
